// File: rtl/core_map.vh
// constants for the instruction timing core: phases, opcodes, sub codes, addresses
`ifndef CORE_MAP_VH
`define CORE_MAP_VH
`define PHASE_FETCH 2'h0
`define PHASE_EXEC 2'h3
`define PC_RESET 12'h000
`define PC_STEP 12'h001
`define PC_LOW_ADDR 8'h06
`define NOP_WORD 16'h0000
`define OP_MISC 4'h0
`define OP_MOVAM 4'h1
`define OP_MOVMA 4'h2
`define OP_MOVAI 4'h3
`define OP_ALUM 4'h4
`define OP_ALUI 4'h5
`define OP_UNARY 4'h6
`define OP_BCLR 4'h7
`define OP_BSET 4'h8
`define OP_SZBIT 4'h9
`define OP_SNZBIT 4'hA
`define OP_SKIP 4'hB
`define OP_JUMP 4'hC
`define OP_CALL 4'hD
`define OP_TABRD 4'hE
`define MISC_HALT 4'h1
`define MISC_CLRWDT 4'h2
`define MISC_SUB_RETURN 4'h3
`define MISC_INT_RETURN 4'h4
`define ALU_ADD 3'h0
`define ALU_ADC 3'h1
`define ALU_SUB 3'h2
`define ALU_SBC 3'h3
`define ALU_AND 3'h4
`define ALU_OR 3'h5
`define ALU_XOR 3'h6
`define ALU_LAST_ARITH 3'h3
`define UN_INC 3'h0
`define UN_DEC 3'h1
`define UN_INVERT 3'h2
`define UN_RR 3'h3
`define UN_RL 3'h4
`define UN_RR_CARRY 3'h5
`define UN_RL_CARRY 3'h6
`define SKIP_ZERO 4'h0
`define SKIP_NONZERO 4'h1
`define BYTE_ONE 8'h01
`define BYTE_ZERO 8'h00
`endif

// File: rtl/mcu_instruction_timing_core.v
// 8-bit microcontroller core with four-clock instruction cycles and fetch discard
`timescale 1ns/1ps
`include "core_map.vh"
// How it works
// - most one cycle; jump, call, returns, table two
// - each instruction cycle is four clocks
// - program counter low write jumps, extra cycle
// - skip costs one more cycle when taken
// - carry above 255, borrow below zero
// - increment/decrement by one, to memory or accumulator
// - logic results of zero set zero flag
// - operands flow through the accumulator
// - rotate one bit left/right, with/without carry
// - rotate via carry swaps out-bit and carry
// - call saves next address, return resumes there
// - skip tests a byte or a bit
// - bit set/clear changes one bit only
// - table read fetches program memory into registers
// - halt powers down; watchdog clear instruction
module mcu_instruction_timing_core #(
	parameter SP_W = 3 // stack pointer width, depth is two to this power
) (
	input wire ref_clk, // system clock
	input wire rst_n, // asynchronous reset, active low
	output reg [11:0] progAddr_r, // program memory address
	input wire [15:0] progData, // program memory word at progAddr_r
	output reg [7:0] dataAddr_r, // data memory address
	input wire [7:0] dataRdData, // data memory byte at dataAddr_r
	output reg [7:0] dataWrData_r, // data memory write byte
	output reg dataWrEn_r, // one-clock write strobe
	output reg [7:0] acc_r, // accumulator
	output reg carry_r, // carry / borrow flag
	output reg zero_r, // zero flag
	output reg powerDown_r, // core halted
	input wire wakeUp, // leaves power-down
	output reg wdtClear_r, // one-clock watchdog clear pulse
	output reg intReturn_r // one-clock pulse on interrupt return
);
	localparam DEPTH = 1 << SP_W; // return stack depth

	reg [1:0] phase_r; // clock within the instruction cycle
	reg [11:0] pc_r; // next fetch address
	reg [15:0] ir_r; // instruction being executed
	reg irValid_r; // ir_r holds a live instruction
	reg tblPend_r; // table read second cycle pending
	reg [11:0] tblAddr_r; // table read program address
	reg [7:0] tblDest_r; // table read destination
	reg [SP_W-1:0] sp_r; // stack pointer
	reg [11:0] stack_r [0:DEPTH-1]; // return addresses
	integer i;

	wire [3:0] opc = ir_r[15:12]; // major opcode
	wire [3:0] sub = ir_r[11:8]; // sub code or bit index
	wire [7:0] imm = ir_r[7:0]; // immediate or data address
	wire [7:0] mem = dataRdData; // operand from data memory

	// add, subtract and logic with carry/borrow out in bit 8
	function [8:0] aluOp;
		input [2:0] op;
		input [7:0] a;
		input [7:0] b;
		input c;
		begin
			case (op)
				`ALU_ADD: aluOp = {1'b0, a} + {1'b0, b};
				`ALU_ADC: aluOp = {1'b0, a} + {1'b0, b} + {8'h00, c};
				`ALU_SUB: aluOp = {1'b0, a} - {1'b0, b};
				`ALU_SBC: aluOp = {1'b0, a} - {1'b0, b} - {8'h00, c};
				`ALU_AND: aluOp = {1'b0, a & b};
				`ALU_OR: aluOp = {1'b0, a | b};
				`ALU_XOR: aluOp = {1'b0, a ^ b};
				default: aluOp = {1'b0, a};
			endcase
		end
	endfunction

	// single-bit mask from a three-bit index
	function [7:0] bitMask;
		input [2:0] idx;
		begin
			bitMask = `BYTE_ONE << idx;
		end
	endfunction

	reg [7:0] res; // result byte
	reg [8:0] aluRes; // alu result with carry
	reg cOut; // new carry
	reg wrM; // write result to memory
	reg wrA; // write result to accumulator
	reg updZ; // update zero flag
	reg updC; // update carry flag
	reg flush; // discard prefetched word
	reg [11:0] tgt; // redirect address
	reg push; // save return address
	reg pop; // take return address
	reg halt; // enter power-down
	reg wdt; // watchdog clear
	reg iret; // interrupt return
	reg tbl; // start table read

	// decode and execute the current instruction
	always @* begin
		res = `BYTE_ZERO;
		aluRes = 9'h000;
		cOut = carry_r;
		wrM = 1'b0;
		wrA = 1'b0;
		updZ = 1'b0;
		updC = 1'b0;
		flush = 1'b0;
		tgt = pc_r;
		push = 1'b0;
		pop = 1'b0;
		halt = 1'b0;
		wdt = 1'b0;
		iret = 1'b0;
		tbl = 1'b0;
		case (opc)
			`OP_MISC: begin
				case (sub)
					`MISC_HALT: halt = 1'b1;
					`MISC_CLRWDT: wdt = 1'b1;
					`MISC_SUB_RETURN, `MISC_INT_RETURN: begin
						pop = 1'b1;
						flush = 1'b1;
						tgt = stack_r[sp_r - {{(SP_W-1){1'b0}}, 1'b1}];
						iret = (sub == `MISC_INT_RETURN);
					end
					default: ; // no operation
				endcase
			end
			`OP_MOVAM: begin
				res = mem;
				wrA = 1'b1;
			end
			`OP_MOVMA: begin
				res = acc_r;
				wrM = 1'b1;
			end
			`OP_MOVAI: begin
				res = imm;
				wrA = 1'b1;
			end
			`OP_ALUM, `OP_ALUI: begin
				aluRes = aluOp(sub[2:0], acc_r, (opc == `OP_ALUI) ? imm : mem, carry_r);
				res = aluRes[7:0];
				cOut = aluRes[8];
				updZ = 1'b1;
				updC = (sub[2:0] <= `ALU_LAST_ARITH);
				wrM = (opc == `OP_ALUM) && sub[3];
				wrA = !wrM;
			end
			`OP_UNARY: begin
				case (sub[2:0])
					`UN_INC: res = mem + `BYTE_ONE;
					`UN_DEC: res = mem - `BYTE_ONE;
					`UN_INVERT: res = ~mem;
					`UN_RR: res = {mem[0], mem[7:1]};
					`UN_RL: res = {mem[6:0], mem[7]};
					`UN_RR_CARRY: begin
						res = {carry_r, mem[7:1]};
						cOut = mem[0];
					end
					`UN_RL_CARRY: begin
						res = {mem[6:0], carry_r};
						cOut = mem[7];
					end
					default: res = mem;
				endcase
				updZ = (sub[2:0] <= `UN_INVERT);
				updC = (sub[2:0] == `UN_RR_CARRY) || (sub[2:0] == `UN_RL_CARRY);
				wrA = sub[3];
				wrM = !sub[3];
			end
			`OP_BCLR: begin
				res = mem & ~bitMask(sub[2:0]);
				wrM = 1'b1;
			end
			`OP_BSET: begin
				res = mem | bitMask(sub[2:0]);
				wrM = 1'b1;
			end
			`OP_SZBIT: flush = !mem[sub[2:0]];
			`OP_SNZBIT: flush = mem[sub[2:0]];
			`OP_SKIP: begin
				if (sub == `SKIP_ZERO)
					flush = (mem == `BYTE_ZERO);
				else if (sub == `SKIP_NONZERO)
					flush = (mem != `BYTE_ZERO);
			end
			`OP_JUMP: begin
				flush = 1'b1;
				tgt = ir_r[11:0];
			end
			`OP_CALL: begin
				flush = 1'b1;
				push = 1'b1;
				tgt = ir_r[11:0];
			end
			`OP_TABRD: tbl = 1'b1;
			default: ; // unused opcode acts as no operation
		endcase
		// a write to the program counter low byte becomes a jump
		if (wrM && (dataAddr_r == `PC_LOW_ADDR)) begin
			wrM = 1'b0;
			flush = 1'b1;
			tgt = {pc_r[11:8], res};
		end
	end

	// four-phase sequencer, fetch, execute and write back
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= `PHASE_FETCH;
			pc_r <= `PC_RESET;
			progAddr_r <= `PC_RESET;
			ir_r <= `NOP_WORD;
			irValid_r <= 1'b0;
			tblPend_r <= 1'b0;
			tblAddr_r <= `PC_RESET;
			tblDest_r <= `BYTE_ZERO;
			sp_r <= {SP_W{1'b0}};
			dataAddr_r <= `BYTE_ZERO;
			dataWrData_r <= `BYTE_ZERO;
			dataWrEn_r <= 1'b0;
			acc_r <= `BYTE_ZERO;
			carry_r <= 1'b0;
			zero_r <= 1'b0;
			powerDown_r <= 1'b0;
			wdtClear_r <= 1'b0;
			intReturn_r <= 1'b0;
			for (i = 0; i < DEPTH; i = i + 1)
				stack_r[i] <= `PC_RESET;
		end else begin
			phase_r <= phase_r + 2'h1;
			dataWrEn_r <= 1'b0;
			wdtClear_r <= 1'b0;
			intReturn_r <= 1'b0;
			if (powerDown_r) begin
				// frozen at cycle start until woken
				phase_r <= `PHASE_FETCH;
				if (wakeUp)
					powerDown_r <= 1'b0;
			end else if (phase_r == `PHASE_FETCH) begin
				if (tblPend_r) begin
					progAddr_r <= tblAddr_r;
				end else begin
					progAddr_r <= pc_r;
					pc_r <= pc_r + `PC_STEP;
					dataAddr_r <= ir_r[7:0];
				end
			end else if (phase_r == `PHASE_EXEC) begin
				if (tblPend_r) begin
					// second cycle: word lands, prefetched word kept
					dataAddr_r <= tblDest_r;
					dataWrData_r <= progData[7:0];
					dataWrEn_r <= 1'b1;
					acc_r <= progData[15:8];
					tblPend_r <= 1'b0;
				end else begin
					ir_r <= progData;
					irValid_r <= !(irValid_r && flush);
					if (irValid_r) begin
						if (flush)
							pc_r <= tgt;
						if (wrA)
							acc_r <= res;
						if (wrM) begin
							dataWrData_r <= res;
							dataWrEn_r <= 1'b1;
						end
						if (updZ)
							zero_r <= (res == `BYTE_ZERO);
						if (updC)
							carry_r <= cOut;
						if (push) begin
							stack_r[sp_r] <= pc_r - `PC_STEP;
							sp_r <= sp_r + {{(SP_W-1){1'b0}}, 1'b1};
						end
						if (pop)
							sp_r <= sp_r - {{(SP_W-1){1'b0}}, 1'b1};
						if (tbl) begin
							tblPend_r <= 1'b1;
							tblAddr_r <= {sub, acc_r};
							tblDest_r <= dataAddr_r;
						end
						if (halt)
							powerDown_r <= 1'b1;
						wdtClear_r <= wdt;
						intReturn_r <= iret;
					end
				end
			end
		end
	end
endmodule // mcu_instruction_timing_core

// File: bench/core_memory.sv
// program and data memory model beside the core
`timescale 1ns/1ps
module core_memory (
	input wire ref_clk, // system clock
	input wire [11:0] progAddr_r, // fetch address
	output wire [15:0] progData, // fetched word
	input wire [7:0] dataAddr_r, // data address
	output wire [7:0] dataRdData, // read byte
	input wire [7:0] dataWrData_r, // write byte
	input wire dataWrEn_r // write strobe
);
	reg [15:0] rom [0:4095]; // program store
	reg [7:0] ram [0:255]; // data store
	assign progData = rom[progAddr_r];
	assign dataRdData = ram[dataAddr_r];
	// store on the strobe
	always @(posedge ref_clk) begin
		if (dataWrEn_r) begin
			ram[dataAddr_r] <= dataWrData_r;
		end
	end
endmodule // core_memory

// File: bench/core_asserts.sv
// port timing checks for the core
`timescale 1ns/1ps
module core_asserts #(
	parameter SP_W = 3 // stack width
) (
	input wire logic ref_clk, // clock
	input wire logic rst_n, // reset
	input wire logic [11:0] progAddr_r, // fetch address
	input wire logic [15:0] progData, // word
	input wire logic [7:0] dataAddr_r, // address
	input wire logic [7:0] dataRdData, // read byte
	input wire logic [7:0] dataWrData_r, // write byte
	input wire logic dataWrEn_r, // strobe
	input wire logic [7:0] acc_r, // accumulator
	input wire logic carry_r, // carry
	input wire logic zero_r, // zero
	input wire logic powerDown_r, // halted
	input wire logic wakeUp, // wake
	input wire logic wdtClear_r, // watchdog pulse
	input wire logic intReturn_r // return pulse
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence addrHeld; $stable(progAddr_r) [*3]; endsequence
	sequence quiet4; !(dataWrEn_r || intReturn_r) [*4]; endsequence
	a_addr_hold: assert property ($changed(progAddr_r) |=> addrHeld)
		else $error("fetch address moved early");
	a_wr_spacing: assert property (dataWrEn_r |=> !dataWrEn_r [*3])
		else $error("writes too close");
	a_strobe_phase: assert property (dataWrEn_r || wdtClear_r |=> $changed(progAddr_r))
		else $error("strobe off phase");
	a_exec_phase: assert property ($changed({acc_r, carry_r, zero_r}) |=> $changed(progAddr_r))
		else $error("result off phase");
	a_ret_bubble: assert property (intReturn_r |=> quiet4)
		else $error("no bubble after return");
	a_wdt_pulse: assert property ($rose(wdtClear_r) |=> !wdtClear_r [*3])
		else $error("watchdog pulse long");
	a_halt_freeze: assert property (powerDown_r && !wakeUp |=> powerDown_r && $stable(progAddr_r))
		else $error("fetch while halted");
	a_halt_quiet: assert property (powerDown_r |-> !dataWrEn_r && !wdtClear_r)
		else $error("execute while halted");
endmodule // core_asserts

// File: bench/tb_mcu_instruction_timing_core.sv
// self-checking bench for the instruction timing core
`timescale 1ns/1ps
module tb_mcu_instruction_timing_core;
	logic ref_clk = 1'b0; // clock
	logic rst_n = 1'b0; // reset
	logic wakeUp = 1'b0; // wake
	wire [11:0] progAddr_r;
	wire [15:0] progData;
	wire [7:0] dataAddr_r, dataRdData, dataWrData_r, acc_r;
	wire dataWrEn_r, carry_r, zero_r, powerDown_r, wdtClear_r, intReturn_r;
	int errors = 0;
	int checksDone = 0;
	int n; // clocks to the marker write
	int wdtSeen; // watchdog clear pulses since reset
	int retSeen; // interrupt return pulses since reset
	always #12.5 ref_clk = ~ref_clk;
	mcu_instruction_timing_core DUT (
		.ref_clk(ref_clk), .rst_n(rst_n), .progAddr_r(progAddr_r), .progData(progData),
		.dataAddr_r(dataAddr_r), .dataRdData(dataRdData), .dataWrData_r(dataWrData_r),
		.dataWrEn_r(dataWrEn_r), .acc_r(acc_r), .carry_r(carry_r), .zero_r(zero_r),
		.powerDown_r(powerDown_r), .wakeUp(wakeUp), .wdtClear_r(wdtClear_r),
		.intReturn_r(intReturn_r)
	);
	core_memory MEM (
		.ref_clk(ref_clk), .progAddr_r(progAddr_r), .progData(progData),
		.dataAddr_r(dataAddr_r), .dataRdData(dataRdData), .dataWrData_r(dataWrData_r),
		.dataWrEn_r(dataWrEn_r)
	);
	// counts one-clock pulses away from the launching edge, cleared in reset
	always @(negedge ref_clk) begin
		if (!rst_n) begin
			wdtSeen <= 0;
			retSeen <= 0;
		end else begin
			if (wdtClear_r === 1'b1) wdtSeen <= wdtSeen + 1;
			if (intReturn_r === 1'b1) retSeen <= retSeen + 1;
		end
	end
	task testDone;
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checksDone++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// reset held, stores cleared
	task wipe;
		@(negedge ref_clk);
		rst_n = 1'b0;
		wakeUp = 1'b0;
		for (int i = 0; i < 4096; i++) MEM.rom[i] = 16'h0000;
		for (int i = 0; i < 256; i++) MEM.ram[i] = 8'h00;
	endtask
	task boot;
		repeat (16) @(negedge ref_clk);
		rst_n = 1'b1;
	endtask
	// counts clocks to a write of byte 20
	task timed(input int lim);
		n = 0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (!(dataWrEn_r === 1'b1 && dataAddr_r === 8'h20) && n < lim);
		if (n >= lim) begin
			errors++;
			$display("mismatch at %0t: no write", $time);
			testDone;
		end
	endtask
	task tJump;
		wipe;
		MEM.rom[0] = 16'hC003;
		MEM.rom[1] = 16'h2020;
		MEM.rom[3] = 16'h2020;
		boot;
		timed(80);
		chk(n[7:0], 8'h10);
	endtask
	task tPcl;
		wipe;
		MEM.rom[0] = 16'h3003;
		MEM.rom[1] = 16'h2006;
		MEM.rom[2] = 16'h2020;
		MEM.rom[3] = 16'h2020;
		MEM.ram[6] = 8'h5A;
		boot;
		timed(80);
		chk(n[7:0], 8'h14);
		chk(MEM.ram[6], 8'h5A);
	endtask
	task tSkip;
		logic [15:0] w [5] = '{16'hB030, 16'hB030, 16'hB130, 16'h9330, 16'hA330};
		logic [7:0] v [5] = '{8'h00, 8'h01, 8'h01, 8'hF7, 8'hF7};
		logic [7:0] e [5] = '{8'h10, 8'h0C, 8'h10, 8'h10, 8'h0C};
		for (int i = 0; i < 5; i++) begin
			wipe;
			MEM.rom[0] = w[i];
			MEM.rom[1] = 16'h2020;
			MEM.rom[2] = 16'h2020;
			MEM.ram[8'h30] = v[i];
			boot;
			timed(80);
			chk(n[7:0], e[i]);
		end
	endtask
	task tCall;
		wipe;
		MEM.rom[0] = 16'hD004;
		MEM.rom[1] = 16'hD006;
		MEM.rom[2] = 16'h2020;
		MEM.rom[4] = 16'h0300;
		MEM.rom[5] = 16'h2020;
		MEM.rom[6] = 16'h0400;
		MEM.rom[7] = 16'h2020;
		boot;
		timed(80);
		chk(n[7:0], 8'h28);
		chk(retSeen[7:0], 8'h01);
	endtask
	task tTable;
		wipe;
		MEM.rom[0] = 16'h3080;
		MEM.rom[1] = 16'hE040;
		MEM.rom[2] = 16'h2020;
		MEM.rom[8'h80] = 16'h5AC3;
		boot;
		timed(80);
		chk(n[7:0], 8'h14);
		chk(dataWrData_r, 8'h5A);
		chk(MEM.ram[8'h40], 8'hC3);
	endtask
	task tData;
		logic [15:0] p [18] = '{16'h30F0, 16'h5020, 16'h5100, 16'h2021, 16'h4A22, 16'h6824,
			16'h2025, 16'h6126, 16'h6527, 16'h6628, 16'h6329, 16'h642A, 16'h722B,
			16'h852C, 16'h622D, 16'h0200, 16'h0100, 16'h2020};
		logic [7:0] b [13] = '{8'h00, 8'h12, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h02, 8'h80,
			8'h01, 8'h81, 8'hFF, 8'h00, 8'hFF};
		logic [7:0] e [13] = '{8'h11, 8'hFF, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h81, 8'h00,
			8'h80, 8'h03, 8'hFB, 8'h20, 8'h00};
		wipe;
		for (int i = 0; i < 18; i++) MEM.rom[i] = p[i];
		for (int i = 0; i < 13; i++) MEM.ram[8'h21 + i[7:0]] = b[i];
		MEM.ram[8'h20] = 8'hFF;
		boot;
		repeat (100) @(negedge ref_clk);
		chk({7'h00, powerDown_r}, 8'h01);
		chk(MEM.ram[8'h20], 8'hFF);
		for (int i = 0; i < 13; i++) chk(MEM.ram[8'h21 + i[7:0]], e[i]);
		chk({6'h00, carry_r, zero_r}, 8'h03);
		chk(acc_r, 8'h00);
		chk(wdtSeen[7:0], 8'h01);
		wakeUp = 1'b1;
		timed(40);
		@(negedge ref_clk);
		chk(MEM.ram[8'h20], 8'h00);
	endtask
	// waits for power-down, bounded
	task halted(input int lim);
		n = 0;
		while (powerDown_r !== 1'b1 && n < lim) begin
			@(negedge ref_clk);
			n++;
		end
		if (powerDown_r !== 1'b1) begin
			errors++;
			$display("mismatch at %0t: no halt", $time);
			testDone;
		end
	endtask
	// one-clock wake pulse
	task wake;
		wakeUp = 1'b1;
		@(negedge ref_clk);
		wakeUp = 1'b0;
	endtask
	// logic ops with a halt after each, then load from memory, add and subtract with borrow before one last halt
	task tLogic;
		logic [15:0] p [11] = '{16'h3055, 16'h54AA, 16'h0100, 16'h550F, 16'h0100, 16'h4631,
			16'h0100, 16'h1032, 16'h50FF, 16'h4333, 16'h0100};
		wipe;
		for (int i = 0; i < 11; i++) MEM.rom[i] = p[i];
		MEM.ram[8'h31] = 8'h0F;
		MEM.ram[8'h32] = 8'h05;
		MEM.ram[8'h33] = 8'h03;
		boot;
		halted(80);
		chk(acc_r, 8'h00);
		chk({7'h00, zero_r}, 8'h01);
		chk(progAddr_r[7:0], 8'h03);
		wake;
		halted(80);
		chk(acc_r, 8'h0F);
		chk({7'h00, zero_r}, 8'h00);
		wake;
		halted(80);
		chk({7'h00, zero_r}, 8'h01);
		wake;
		halted(80);
		chk({6'h00, carry_r, zero_r}, 8'h01);
		chk(acc_r, 8'h00);
	endtask
	initial begin
		tJump;
		tPcl;
		tSkip;
		tCall;
		tTable;
		tData;
		tLogic;
		testDone;
	end
endmodule // tb_mcu_instruction_timing_core
bind mcu_instruction_timing_core core_asserts #(.SP_W(SP_W)) CHK (.ref_clk, .rst_n, .progAddr_r,
	.progData, .dataAddr_r, .dataRdData, .dataWrData_r, .dataWrEn_r, .acc_r, .carry_r, .zero_r,
	.powerDown_r, .wakeUp, .wdtClear_r, .intReturn_r);
